// ===== lane_map_pkg.sv
// Shared constants and types for the serial lane map and status block
package lane_map_pkg;
  localparam int NUM_LANES = 16;
  localparam int LANE_W = 4;
  localparam int ARR_W = 6;
  localparam int IDX_W = 10;
  localparam int ADDR_W = 12;
  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LINK_CTRL = 10'h120;
  localparam logic [IDX_W-1:0] IDX_ARR_STAT = 10'h12c;
  localparam logic [IDX_W-1:0] IDX_POL_FLIP = 10'h12e;
  localparam logic [IDX_W-1:0] IDX_LANE_SRC = 10'h130;
  localparam logic [IDX_W-1:0] IDX_ARR_TIME = 10'h140;
  localparam logic [IDX_W-1:0] IDX_LOCK_STATE = 10'h150;
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int ARR_VALID_BIT = 0;
  localparam int STAT_SIG_BIT = 0;
  localparam int STAT_CG_BIT = 1;
  localparam int STAT_FR_BIT = 2;
  // Reset values
  localparam logic [15:0] POL_FLIP_RST = 16'h0000;
  localparam logic [1:0] LINK_CTRL_RST = 2'h0;
  localparam logic [3:0] LANE_SRC_RSVD_RST = 4'h0;

  typedef struct packed {
    logic frame_emb_lock;
    logic codegroup_block_lock;
    logic signal_present;
  } lane_lock_s;
endpackage : lane_map_pkg

// ===== lane_word_store.sv
// Small word store that loads every word at once and reads one registered
`timescale 1ns/10ps
`default_nettype none
module lane_word_store #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic load_all,
  input wire logic [DEPTH-1:0][WIDTH-1:0] load_data,
  input wire logic [AW-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_word
);
  logic [DEPTH-1:0][WIDTH-1:0] mem_q;

  // One load replaces every word, so the set never mixes two loads
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mem_q <= '0;
    end else if (load_all) begin
      mem_q <= load_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_word <= '0;
    end else begin
      rd_word <= mem_q[rd_idx];
    end
  end
endmodule : lane_word_store
`default_nettype wire

// ===== serial_lane_map_status.sv
// Lane polarity, crossbar, arrival capture and lock status with APB access
//
// Summary of operation
// [R1] Flip bits of physical lanes marked for inversion
// [R2] Software flips lanes whose pair is swapped
// [R3] Sixteen independent logical lane source selectors
// [R4] Selector value p routes physical p to n
// [R5] Selectors reset to identity mapping
// [R6] Lane zero entry sits at lowest address
// [R7] Change selectors only while link disabled
// [R8] Report per-lane arrival against LMFC/LEMC boundary
// [R9] Arrival time is six bits, 0 to 63
// [R10] Arrival times valid only when valid flag set
// [R11] Capture at buffer release attempt if unflagged
// [R12] All sixteen values from one release attempt
// [R13] Software pulses link reset for accurate arrivals
// [R14] Status bit 2 shows frame/EMB lock
// [R15] Status bit 1 shows code-group/block lock
// [R16] Status bit 0 shows signal present
// [R17] Valid flag sets on capture, clears when idle
// [R18] Inversion applies per physical lane before crossbar
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module serial_lane_map_status #(
  parameter int DATA_W = 40
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lane_map_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [lane_map_pkg::NUM_LANES-1:0][DATA_W-1:0] phys_rx_data,
  output logic [lane_map_pkg::NUM_LANES-1:0][DATA_W-1:0] logical_rx_data,
  input wire logic lmfc_tick,
  input wire logic [lane_map_pkg::NUM_LANES-1:0] lane_arrive,
  input wire logic buf_release_try,
  input wire lane_map_pkg::lane_lock_s [lane_map_pkg::NUM_LANES-1:0] lane_lock,
  output logic link_block_enable,
  output logic link_block_reset,
  output logic arrival_capture_valid
);
  localparam int NL = lane_map_pkg::NUM_LANES;
  localparam int LW = lane_map_pkg::LANE_W;
  localparam int AW = lane_map_pkg::ARR_W;

  logic [15:0] flip_q;
  logic [NL-1:0][7:0] src_q;
  logic [NL-1:0] sig_meta_q;
  logic [NL-1:0] sig_sync_q;
  logic [AW-1:0] phase_q;
  logic [NL-1:0][AW-1:0] pending_q;
  logic [AW-1:0] arr_word;
  logic [NL-1:0][DATA_W-1:0] flipped;
  logic [lane_map_pkg::IDX_W-1:0] idx;
  logic access;
  logic wr_done;
  logic capture;
  logic [31:0] rdata_d;
  logic err_d;

  // Decodes whether an index falls inside a sixteen-entry array
  function automatic logic in_array(
    input logic [lane_map_pkg::IDX_W-1:0] i,
    input logic [lane_map_pkg::IDX_W-1:0] base
  );
    in_array = (i[lane_map_pkg::IDX_W-1:LW] == base[lane_map_pkg::IDX_W-1:LW]);
  endfunction : in_array

  assign idx = paddr[lane_map_pkg::ADDR_W-1:2];
  assign access = psel && penable;
  assign wr_done = access && pready && pwrite && !pslverr;
  assign capture = buf_release_try && !arrival_capture_valid &&
                   link_block_enable && !link_block_reset;

  // Polarity is tied to the physical pair, so it is applied first
  always_comb begin
    for (int p = 0; p < NL; p++) begin
      flipped[p] = phys_rx_data[p] ^ {DATA_W{flip_q[p]}}; // see [R1] [R18]
    end
  end

  generate
    for (genvar n = 0; n < NL; n++) begin : g_xbar
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          logical_rx_data[n] <= '0;
        end else begin
          logical_rx_data[n] <= flipped[src_q[n][LW-1:0]]; // see [R3] [R4]
        end
      end
    end
  endgenerate

  // Loss-of-signal detector is analog, so its level is synchronised
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sig_meta_q <= '0;
      sig_sync_q <= '0;
    end else begin
      for (int n = 0; n < NL; n++) begin
        sig_meta_q[n] <= lane_lock[n].signal_present;
      end
      sig_sync_q <= sig_meta_q;
    end
  end

  // Phase wraps at 64 whatever the multiframe length
  always_ff @(posedge ref_clk) begin
    if (srst || lmfc_tick) begin
      phase_q <= '0; // see [R8] [R9]
    end else begin
      phase_q <= phase_q + 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pending_q <= '0;
    end else begin
      for (int n = 0; n < NL; n++) begin
        if (lane_arrive[n]) begin
          pending_q[n] <= phase_q; // see [R8]
        end
      end
    end
  end

  // Flag clear dominates: an idle or held link cannot own a capture
  always_ff @(posedge ref_clk) begin
    if (srst || !link_block_enable || link_block_reset) begin
      arrival_capture_valid <= 1'b0; // see [R17]
    end else if (capture) begin
      arrival_capture_valid <= 1'b1; // see [R11] [R17]
    end
  end

  lane_word_store #(
    .WIDTH(AW),
    .DEPTH(NL),
    .AW(LW)
  ) u_arr_store (
    .ref_clk(ref_clk),
    .srst(srst),
    .load_all(capture), // see [R11] [R12]
    .load_data(pending_q),
    .rd_idx(idx[LW-1:0]), // see [R6]
    .rd_word(arr_word)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      link_block_enable <= lane_map_pkg::LINK_CTRL_RST[lane_map_pkg::CTRL_EN_BIT];
      link_block_reset <= lane_map_pkg::LINK_CTRL_RST[lane_map_pkg::CTRL_RST_BIT];
    end else if (wr_done && idx == lane_map_pkg::IDX_LINK_CTRL) begin
      link_block_enable <= pwdata[lane_map_pkg::CTRL_EN_BIT];
      link_block_reset <= pwdata[lane_map_pkg::CTRL_RST_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flip_q <= lane_map_pkg::POL_FLIP_RST;
    end else if (wr_done && idx == lane_map_pkg::IDX_POL_FLIP) begin
      flip_q <= pwdata[15:0]; // see [R1]
    end
  end

  // Selectors are writable at any time; a change while enabled may glitch
  always_ff @(posedge ref_clk) begin
    for (int n = 0; n < NL; n++) begin
      if (srst) begin
        src_q[n] <= {lane_map_pkg::LANE_SRC_RSVD_RST, LW'(n)}; // see [R5]
      end else if (wr_done && in_array(idx, lane_map_pkg::IDX_LANE_SRC) &&
                   idx[LW-1:0] == LW'(n)) begin
        src_q[n] <= pwdata[7:0]; // see [R4] [R6]
      end
    end
  end

  // Read mux; arrival words come from the store one cycle after setup
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (idx == lane_map_pkg::IDX_LINK_CTRL) begin
      rdata_d[lane_map_pkg::CTRL_EN_BIT] = link_block_enable;
      rdata_d[lane_map_pkg::CTRL_RST_BIT] = link_block_reset;
    end else if (idx == lane_map_pkg::IDX_ARR_STAT) begin
      rdata_d[lane_map_pkg::ARR_VALID_BIT] = arrival_capture_valid; // see [R10]
    end else if (idx == lane_map_pkg::IDX_POL_FLIP) begin
      rdata_d[15:0] = flip_q;
    end else if (in_array(idx, lane_map_pkg::IDX_LANE_SRC)) begin
      rdata_d[7:0] = src_q[idx[LW-1:0]];
    end else if (in_array(idx, lane_map_pkg::IDX_ARR_TIME)) begin
      rdata_d[AW-1:0] = arr_word; // see [R9]
    end else if (in_array(idx, lane_map_pkg::IDX_LOCK_STATE)) begin
      rdata_d[lane_map_pkg::STAT_FR_BIT] =
        lane_lock[idx[LW-1:0]].frame_emb_lock; // see [R14]
      rdata_d[lane_map_pkg::STAT_CG_BIT] =
        lane_lock[idx[LW-1:0]].codegroup_block_lock; // see [R15]
      rdata_d[lane_map_pkg::STAT_SIG_BIT] = sig_sync_q[idx[LW-1:0]]; // see [R16]
    end else begin
      err_d = 1'b1;
    end
  end

  // Two-cycle access phase gives the store time to present its word
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access && !pready;
      if (access && !pready) begin
        pslverr <= err_d;
        prdata <= pwrite ? 32'h0000_0000 : rdata_d;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  logic [DATA_W-1:0] exp_lane0;
  assign exp_lane0 = phys_rx_data[src_q[0][LW-1:0]] ^
                     {DATA_W{flip_q[src_q[0][LW-1:0]]}};

  AST_LANE0_ROUTE: assert property (@(posedge ref_clk) disable iff (srst) // see [R1]
    !$past(srst) |-> logical_rx_data[0] == $past(exp_lane0))
    else $error("Logical lane 0 does not carry its selected physical lane");

  AST_SRC_RESET: assert property (@(posedge ref_clk) // see [R5]
    $past(srst) && srst |-> src_q[5] == 8'h05 && src_q[15] == 8'h0f)
    else $error("Selector reset is not identity");

  AST_SRC_WRITE: assert property (@(posedge ref_clk) disable iff (srst) // see [R4]
    wr_done && idx == lane_map_pkg::IDX_LANE_SRC + 10'h003
      |=> src_q[3] == $past(pwdata[7:0]))
    else $error("Selector write did not land in entry three");

  AST_FLIP_WRITE: assert property (@(posedge ref_clk) disable iff (srst) // see [R1]
    wr_done && idx == lane_map_pkg::IDX_POL_FLIP |=> flip_q == $past(pwdata[15:0]))
    else $error("Polarity write lost");

  AST_VALID_CLEAR: assert property (@(posedge ref_clk) disable iff (srst) // see [R17]
    !link_block_enable || link_block_reset |=> !arrival_capture_valid)
    else $error("Capture flag survived a disabled or held link");

  AST_VALID_SET: assert property (@(posedge ref_clk) disable iff (srst) // see [R11]
    $rose(arrival_capture_valid) |-> $past(buf_release_try) && $past(link_block_enable))
    else $error("Capture flag rose without a release attempt");

  AST_SINGLE_LOAD: assert property (@(posedge ref_clk) disable iff (srst) // see [R12]
    capture |-> !arrival_capture_valid ##1 arrival_capture_valid)
    else $error("Arrival store loaded while already captured");

  AST_PHASE_WRAP: assert property (@(posedge ref_clk) disable iff (srst) // see [R9]
    !lmfc_tick && phase_q == 6'h3f |=> phase_q == 6'h00)
    else $error("Arrival phase does not wrap at 63");

  AST_READY_PULSE: assert property (@(posedge ref_clk) disable iff (srst) // see the APB register port, our own choice
    psel && !penable ##1 access [*2] |-> pready ##1 !pready)
    else $error("Access phase is not two cycles");

  AST_STAT_RSVD: assert property (@(posedge ref_clk) disable iff (srst) // see [R16]
    pready && !pwrite && in_array($past(idx), lane_map_pkg::IDX_LOCK_STATE)
      |-> prdata[31:3] == 29'h0000_0000)
    else $error("Lock status reserved bits not zero");

  AST_PHASE_TICK: assert property ( // see [R8]
    @(posedge ref_clk) disable iff (srst)
    lmfc_tick |=> phase_q == 6'h00)
    else $error("Arrival phase not restarted by boundary tick");

  AST_SNAPSHOT: assert property ( // see [R12]
    @(posedge ref_clk) disable iff (srst)
    capture |=> u_arr_store.mem_q == $past(pending_q))
    else $error("Arrival store does not hold one snapshot");

  AST_NO_RELOAD: assert property ( // see [R11]
    @(posedge ref_clk) disable iff (srst)
    arrival_capture_valid |=> u_arr_store.mem_q == $past(u_arr_store.mem_q))
    else $error("Arrival store reloaded while flag was set");

  AST_VALID_HOLD: assert property ( // see [R17]
    @(posedge ref_clk) disable iff (srst)
    arrival_capture_valid && link_block_enable && !link_block_reset
      |=> arrival_capture_valid)
    else $error("Capture flag dropped while link stayed up");

  AST_ARR_RSVD: assert property ( // see [R9]
    @(posedge ref_clk) disable iff (srst)
    pready && !pwrite && in_array($past(idx), lane_map_pkg::IDX_ARR_TIME)
      |-> prdata[31:6] == 26'h0)
    else $error("Arrival word wider than six bits");

  AST_SIG_SYNC: assert property ( // see [R16]
    @(posedge ref_clk) disable iff (srst)
    !$past(srst) && !$past(srst, 2)
      |-> sig_sync_q[0] == $past(lane_lock[0].signal_present, 2))
    else $error("Signal-present level not passed through two stages");

  CVR_CAPTURE: cover property (@(posedge ref_clk) disable iff (srst)
    capture);
  CVR_REMAP: cover property (@(posedge ref_clk) disable iff (srst)
    wr_done && in_array(idx, lane_map_pkg::IDX_LANE_SRC));
  CVR_ARR_READ: cover property (@(posedge ref_clk) disable iff (srst)
    pready && !pwrite && arrival_capture_valid);
  CVR_UNMAPPED: cover property (@(posedge ref_clk) disable iff (srst)
    pready && pslverr);
endmodule : serial_lane_map_status
`default_nettype wire

// ===== lane_tx_model.sv
// Transmitter-side model: lane data, LMFC ticks, arrivals, lock levels
`timescale 1ns/10ps
`default_nettype none
module lane_tx_model #(
  parameter int DATA_W = 40
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic go,
  input wire logic [2:0] step,
  input wire lane_map_pkg::lane_lock_s [15:0] lock_pat,
  output logic [15:0][DATA_W-1:0] phys_rx_data,
  output logic lmfc_tick,
  output logic [15:0] lane_arrive,
  output logic buf_release_try,
  output lane_map_pkg::lane_lock_s [15:0] lane_lock
);
  logic [5:0] ph_q;
  logic [31:0] cnt_q;
  logic armed_q;
  logic run_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ph_q <= 6'h0;
      cnt_q <= 32'h0;
    end else begin
      ph_q <= ph_q + 6'h1;
      cnt_q <= cnt_q + 32'h1;
    end
  end
  // One burst of arrivals per go, inside a single frame
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      armed_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      if (go) armed_q <= 1'b1;
      if (armed_q && ph_q == 6'h3f) begin
        run_q <= 1'b1;
        armed_q <= 1'b0;
      end
      if (run_q && ph_q == 6'h3e) run_q <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    lane_lock <= lock_pat;
  end
  // Every other boundary is skipped so the block's phase must wrap alone
  assign lmfc_tick = (ph_q == 6'h3f) && !cnt_q[6];
  assign buf_release_try = run_q && ph_q == 6'h3c;
  // Data changes every cycle so a stale word never matches
  always_comb begin
    for (int p = 0; p < 16; p++) begin
      phys_rx_data[p] = {cnt_q, 8'(p)};
      lane_arrive[p] = run_q && ph_q == 6'(step * p + 2);
    end
  end
endmodule : lane_tx_model
`default_nettype wire

// ===== test_serial_lane_map_status.sv
// Testbench: APB register access, crossbar data, lock and arrival checks
`timescale 1ns/10ps
`default_nettype none
module test_serial_lane_map_status;
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0][39:0] phys, logical, phys_q;
  logic lmfc_tick, buf_release_try, link_block_enable, link_block_reset;
  logic arrival_capture_valid, e;
  logic [15:0] lane_arrive, flip_v;
  logic [2:0] step;
  logic [3:0] src [16];
  lane_map_pkg::lane_lock_s [15:0] lane_lock, lock_pat;
  int num_errors, n_checks;
  serial_lane_map_status #(.DATA_W(40)) dut (.ref_clk(ref_clk),
    .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phys_rx_data(phys), .logical_rx_data(logical),
    .lmfc_tick(lmfc_tick), .lane_arrive(lane_arrive),
    .buf_release_try(buf_release_try), .lane_lock(lane_lock),
    .link_block_enable(link_block_enable),
    .link_block_reset(link_block_reset),
    .arrival_capture_valid(arrival_capture_valid));
  lane_tx_model #(.DATA_W(40)) tx (.ref_clk(ref_clk), .srst(srst),
    .go(go), .step(step), .lock_pat(lock_pat), .phys_rx_data(phys),
    .lmfc_tick(lmfc_tick), .lane_arrive(lane_arrive),
    .buf_release_try(buf_release_try), .lane_lock(lane_lock));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) phys_q <= phys;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk
  // Request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(n < 50, "no pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d, r, e);
    chk(e === 1'b0, "write error");
  endtask : wr
  task automatic rd_chk(input logic [9:0] i, input logic [31:0] x);
    apb(1'b0, {i, 2'b00}, 32'h0, r, e);
    chk(r === x && e === 1'b0, $sformatf("read %h got %h", i, r));
  endtask : rd_chk
  task automatic chk_data;
    @(negedge ref_clk);
    for (int n = 0; n < 16; n++)
      chk(logical[n] === (phys_q[src[n]] ^ {40{flip_v[src[n]]}}), "data");
  endtask : chk_data
  task automatic arr_run(input logic [2:0] s);
    @(posedge ref_clk);
    step <= s;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (200) @(posedge ref_clk);
  endtask : arr_run
  // The model lands lane n at phase s*n+2 after a boundary
  task automatic arr_chk(input int s);
    for (int n = 0; n < 16; n++) begin
      apb(1'b0, {lane_map_pkg::IDX_ARR_TIME + 10'(n), 2'b00}, 32'h0, r, e);
      chk(r === {26'h0, 6'(s * n + 2)} && e === 1'b0, "arr");
    end
  endtask : arr_chk
  initial begin
    {srst, psel, penable, pwrite, go} = 5'h10;
    {paddr, pwdata, step, lock_pat} = '0;
    num_errors = 0;
    n_checks = 0;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    rd_chk(lane_map_pkg::IDX_POL_FLIP, 32'h0);
    rd_chk(lane_map_pkg::IDX_ARR_STAT, 32'h0);
    rd_chk(lane_map_pkg::IDX_LINK_CTRL, 32'h0);
    for (int n = 0; n < 16; n++)
      rd_chk(lane_map_pkg::IDX_LANE_SRC + 10'(n), 32'(n));
    apb(1'b1, 12'hffc, 32'h1, r, e);
    chk(e === 1'b1, "unmapped accepted");
    wr(lane_map_pkg::IDX_ARR_TIME, 32'h3f);
    rd_chk(lane_map_pkg::IDX_ARR_TIME, 32'h0);
    $display("test reset done");
    flip_v = 16'h8005;
    wr(lane_map_pkg::IDX_POL_FLIP, 32'(flip_v));
    for (int k = 0; k < 2; k++) begin
      for (int n = 0; n < 16; n++) begin
        src[n] = k ? 4'h2 : 4'(15 - n);
        wr(lane_map_pkg::IDX_LANE_SRC + 10'(n), 32'(src[n]));
        rd_chk(lane_map_pkg::IDX_LANE_SRC + 10'(n), 32'(src[n]));
      end
      chk_data;
    end
    $display("test crossbar done");
    for (int k = 0; k < 2; k++) begin
      for (int n = 0; n < 16; n++) lock_pat[n] <= 3'(n ^ (k * 7));
      repeat (6) @(posedge ref_clk);
      for (int n = 0; n < 16; n++)
        rd_chk(lane_map_pkg::IDX_LOCK_STATE + 10'(n),
          {29'h0, 3'(n ^ (k * 7))});
    end
    $display("test status done");
    wr(lane_map_pkg::IDX_LINK_CTRL, 32'h1);
    @(negedge ref_clk);
    chk(link_block_enable === 1'b1 && link_block_reset === 1'b0, "enable");
    rd_chk(lane_map_pkg::IDX_LINK_CTRL, 32'h1);
    arr_run(3'h3);
    chk(arrival_capture_valid === 1'b1, "flag pin");
    rd_chk(lane_map_pkg::IDX_ARR_STAT, 32'h1);
    arr_chk(3);
    arr_run(3'h1);
    arr_chk(3);
    wr(lane_map_pkg::IDX_LINK_CTRL, 32'h3);
    @(negedge ref_clk);
    chk(link_block_reset === 1'b1, "link reset");
    rd_chk(lane_map_pkg::IDX_LINK_CTRL, 32'h3);
    rd_chk(lane_map_pkg::IDX_ARR_STAT, 32'h0);
    wr(lane_map_pkg::IDX_LINK_CTRL, 32'h1);
    arr_run(3'h1);
    rd_chk(lane_map_pkg::IDX_ARR_STAT, 32'h1);
    arr_chk(1);
    wr(lane_map_pkg::IDX_LINK_CTRL, 32'h0);
    rd_chk(lane_map_pkg::IDX_ARR_STAT, 32'h0);
    $display("test arrival done");
    stop_test;
  end
  // Whole run needs under two thousand cycles
  initial begin
    #500000;
    num_errors++;
    $display("FAIL %0t watchdog", $time);
    stop_test;
  end
endmodule : test_serial_lane_map_status
`default_nettype wire
